// ===== design/cfg_bits_pkg.sv
// constants shared by the calibration configuration bit store
package cfg_bits_pkg;

	// bit array geometry
	localparam int unsigned CFG_BITS = 56;
	localparam int unsigned ADDR_W = 6;
	localparam logic [5:0] CFG_LAST_ADDR = 6'h37;

	// listed (most significant) address and width of each trim field
	localparam logic [5:0] PHASE_COMP_ADDR = 6'h15;
	localparam int unsigned PHASE_COMP_W = 4;
	localparam logic [5:0] VOLTAGE_GAIN_ADDR = 6'h1A;
	localparam int unsigned VOLTAGE_GAIN_W = 8;
	localparam logic [5:0] SECONDARY_GAIN_ADDR = 6'h28;
	localparam int unsigned SECONDARY_GAIN_W = 8;
	localparam logic [5:0] OSC_TRIM_ADDR = 6'h31;
	localparam int unsigned OSC_TRIM_W = 2;
	localparam logic [5:0] TAMPER_SEL_ADDR = 6'h35;

	// oscillator trim code that raises the frequency; other codes leave it nominal
	localparam logic [1:0] OSC_TRIM_RAISE = 2'h1;

	// reserved addresses: writes are dropped and the bits read as zero
	localparam logic [55:0] RESERVED_MASK = 56'hD8_0000_0003_0040;
	localparam logic [55:0] CFG_RESET_VALUE = 56'h00_0000_0000_0000;

	// remote reset pin sequence: every step longer than the minimum time
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned STEP_MIN_NS = 30;
	localparam int unsigned STEP_MIN_CYC = (STEP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STEP_CNT_W = 3;
	localparam logic [2:0] STEP_MIN_CNT = 3'(STEP_MIN_CYC);
	localparam logic [2:0] STEP_CNT_ZERO = 3'h0;
	localparam logic [2:0] STEP_CNT_ONE = 3'h1;

	// remote reset sequence detector states
	typedef enum logic [3:0] {
		RST_IDLE = 4'h1,
		RST_SYN_LOW = 4'h2,
		RST_SEL_LOW = 4'h4,
		RST_SEL_HIGH = 4'h8
	} rrr_state_t;

	// gather a field whose most significant bit sits at the listed address
	function automatic logic [7:0] field_get(input logic [55:0] bits, input int unsigned msb,
		input int unsigned w);
		logic [7:0] v;
		v = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			if (i < w)
				v[w - 1 - i] = bits[msb + i];
		end
		return v;
	endfunction : field_get

endpackage : cfg_bits_pkg

// ===== design/cfg_bit_store.sv
// volatile store of the 56 configuration bits with a registered read port
`timescale 1ns/10ps
`default_nettype none

module cfg_bit_store (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic wr_en,
	input wire logic [5:0] wr_addr,
	input wire logic wr_bit,
	input wire logic [5:0] rd_addr,
	output logic rd_bit_reg,
	output logic [55:0] bits_reg
);

	// one flop per bit; reserved positions never load so they stay zero
	// reserved writes dropped
	genvar g;
	generate
		for (g = 0; g < cfg_bits_pkg::CFG_BITS; g++)
		begin : g_bit
			always_ff @(posedge clk_sys)
			begin
				if (!reset_n)
					bits_reg[g] <= cfg_bits_pkg::CFG_RESET_VALUE[g];
				else if (wr_en && wr_addr == 6'(g) && !cfg_bits_pkg::RESERVED_MASK[g])
					bits_reg[g] <= wr_bit;
			end
		end
	endgenerate

	// read back one bit; addresses past the array answer zero
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			rd_bit_reg <= 1'b0;
		else if (rd_addr > cfg_bits_pkg::CFG_LAST_ADDR)
			rd_bit_reg <= 1'b0;
		else
			rd_bit_reg <= bits_reg[rd_addr];
	end

endmodule : cfg_bit_store

`default_nettype wire

// ===== design/remote_reset_detect.sv
// watches the serial select, sync and clock pins for the remote reset sequence
`timescale 1ns/10ps
`default_nettype none

module remote_reset_detect (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic sel_n_in,
	input wire logic sync_in,
	input wire logic sclk_in,
	output logic request_reg
);

	cfg_bits_pkg::rrr_state_t state_reg;
	cfg_bits_pkg::rrr_state_t state_next;
	logic [2:0] cnt_reg;
	logic long_enough;
	logic fire;

	assign long_enough = cnt_reg >= cfg_bits_pkg::STEP_MIN_CNT;

	// next state; any unexpected pin change abandons the sequence
	always_comb
	begin
		state_next = cfg_bits_pkg::RST_IDLE;
		fire = 1'b0;
		unique case (state_reg)
			cfg_bits_pkg::RST_IDLE:
				if (long_enough && sel_n_in && sclk_in && !sync_in)
					state_next = cfg_bits_pkg::RST_SYN_LOW;
			cfg_bits_pkg::RST_SYN_LOW:
				if (sel_n_in && sclk_in && !sync_in)
					state_next = cfg_bits_pkg::RST_SYN_LOW;
				else if (long_enough && !sel_n_in && sclk_in && !sync_in)
					state_next = cfg_bits_pkg::RST_SEL_LOW;
			cfg_bits_pkg::RST_SEL_LOW:
				if (!sel_n_in && sclk_in && !sync_in)
					state_next = cfg_bits_pkg::RST_SEL_LOW;
				else if (long_enough && sel_n_in && sclk_in && !sync_in)
					state_next = cfg_bits_pkg::RST_SEL_HIGH;
			cfg_bits_pkg::RST_SEL_HIGH:
				if (sel_n_in && sclk_in && !sync_in)
					state_next = cfg_bits_pkg::RST_SEL_HIGH;
				else if (long_enough && sel_n_in && sclk_in && sync_in)
					fire = 1'b1;
			default:
				state_next = cfg_bits_pkg::RST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			state_reg <= cfg_bits_pkg::RST_IDLE;
		else
			state_reg <= state_next;
	end

	// time spent in the present step, saturating at the minimum
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			cnt_reg <= cfg_bits_pkg::STEP_CNT_ZERO;
		else if (state_next != state_reg || (state_reg == cfg_bits_pkg::RST_IDLE &&
			!(sel_n_in && sync_in && sclk_in)))
			cnt_reg <= cfg_bits_pkg::STEP_CNT_ZERO;
		else if (!long_enough)
			cnt_reg <= cnt_reg + cfg_bits_pkg::STEP_CNT_ONE;
	end

	// one-cycle request on the final sync rise
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			request_reg <= 1'b0;
		else
			request_reg <= fire;
	end

endmodule : remote_reset_detect

`default_nettype wire

// ===== design/metering_calibration_config_bits.sv
// calibration trim bits of the metering core and the remote reset detector
`timescale 1ns/10ps
`default_nettype none

module metering_calibration_config_bits (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic cfg_wr_en,
	input wire logic [5:0] cfg_wr_addr,
	input wire logic cfg_wr_bit,
	input wire logic [5:0] cfg_rd_addr,
	input wire logic sel_n_in,
	input wire logic sync_in,
	input wire logic sclk_in,
	output logic cfg_rd_bit,
	output logic [3:0] phase_comp,
	output logic [7:0] voltage_gain_trim,
	output logic [7:0] secondary_current_gain_trim,
	output logic [1:0] oscillator_trim,
	output logic osc_freq_raise,
	output logic tamper_threshold_sel,
	output logic remote_reset_request
);

	logic [55:0] cfg_bits;
	logic [3:0] phase_comp_reg;
	logic [7:0] voltage_gain_reg;
	logic [7:0] secondary_gain_reg;
	logic [1:0] osc_trim_reg;
	logic osc_raise_reg;
	logic tamper_sel_reg;
	logic [7:0] osc_field;
	logic [7:0] phase_field;

	cfg_bit_store u_store (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.wr_en(cfg_wr_en),
		.wr_addr(cfg_wr_addr),
		.wr_bit(cfg_wr_bit),
		.rd_addr(cfg_rd_addr),
		.rd_bit_reg(cfg_rd_bit),
		.bits_reg(cfg_bits)
	);

	remote_reset_detect u_rrr (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.sel_n_in(sel_n_in),
		.sync_in(sync_in),
		.sclk_in(sclk_in),
		.request_reg(remote_reset_request)
	);

	assign osc_field = cfg_bits_pkg::field_get(cfg_bits, cfg_bits_pkg::OSC_TRIM_ADDR,
		cfg_bits_pkg::OSC_TRIM_W);
	// a function result cannot be part-selected, so the phase field gets its own net
	assign phase_field = cfg_bits_pkg::field_get(cfg_bits, cfg_bits_pkg::PHASE_COMP_ADDR,
		cfg_bits_pkg::PHASE_COMP_W);

	// remote request not wired to any reset
	// fields assembled msb-first from the listed address upward
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			phase_comp_reg <= 4'h0;
		else
			phase_comp_reg <= phase_field[3:0];
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			voltage_gain_reg <= 8'h00;
		else
			voltage_gain_reg <= cfg_bits_pkg::field_get(cfg_bits,
				cfg_bits_pkg::VOLTAGE_GAIN_ADDR, cfg_bits_pkg::VOLTAGE_GAIN_W);
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			secondary_gain_reg <= 8'h00;
		else
			secondary_gain_reg <= cfg_bits_pkg::field_get(cfg_bits,
				cfg_bits_pkg::SECONDARY_GAIN_ADDR, cfg_bits_pkg::SECONDARY_GAIN_W);
	end

	// oscillator trim and its decoded speed-up; code 2 is left nominal as well
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			osc_trim_reg <= 2'h0;
			osc_raise_reg <= 1'b0;
		end
		else
		begin
			osc_trim_reg <= osc_field[1:0];
			osc_raise_reg <= osc_field[1:0] == cfg_bits_pkg::OSC_TRIM_RAISE;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			tamper_sel_reg <= 1'b0;
		else
			tamper_sel_reg <= cfg_bits[cfg_bits_pkg::TAMPER_SEL_ADDR];
	end

	// outputs follow the store two edges after the write, no staging
	assign phase_comp = phase_comp_reg;
	assign voltage_gain_trim = voltage_gain_reg;
	assign secondary_current_gain_trim = secondary_gain_reg;
	assign oscillator_trim = osc_trim_reg;
	assign osc_freq_raise = osc_raise_reg;
	assign tamper_threshold_sel = tamper_sel_reg;

	// checks on the mapping, reset and remote reset behaviour
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	property p_field_bit(logic [5:0] a, logic obs);
		cfg_wr_en && cfg_wr_addr == a ##1 !(cfg_wr_en && cfg_wr_addr == a)
			|=> obs == $past(cfg_wr_bit, 2);
	endproperty

	AST_PHASE_MSB: assert property (p_field_bit(cfg_bits_pkg::PHASE_COMP_ADDR, phase_comp[3]))
		else $error("phase compensation msb does not follow its write");

	AST_PHASE_LSB: assert property (p_field_bit(6'h18, phase_comp[0]))
		else $error("phase compensation lsb not at listed address plus three");

	AST_VGAIN_LSB: assert property (p_field_bit(6'h21, voltage_gain_trim[0]))
		else $error("voltage gain lsb mapping wrong");

	AST_SGAIN_MSB: assert property (p_field_bit(cfg_bits_pkg::SECONDARY_GAIN_ADDR,
		secondary_current_gain_trim[7]))
		else $error("secondary gain msb mapping wrong");

	AST_TAMPER_SEL: assert property (p_field_bit(cfg_bits_pkg::TAMPER_SEL_ADDR,
		tamper_threshold_sel))
		else $error("tamper threshold select does not follow its write");

	AST_OSC_RAISE: assert property (
		osc_freq_raise == (oscillator_trim == cfg_bits_pkg::OSC_TRIM_RAISE))
		else $error("oscillator speed-up disagrees with trim code");

	AST_OUT_OF_RANGE: assert property (
		cfg_wr_en && cfg_wr_addr > cfg_bits_pkg::CFG_LAST_ADDR |=> $stable(cfg_bits))
		else $error("write past the last address changed the store");

	AST_RESERVED: assert property (
		cfg_wr_en && cfg_bits_pkg::RESERVED_MASK[cfg_wr_addr] |=> $stable(cfg_bits)
			##1 cfg_rd_addr == $past(cfg_wr_addr, 2) |-> ##1 !cfg_rd_bit)
		else $error("reserved address write took effect");

	AST_POR_CLEAR: assert property (@(posedge clk_sys) disable iff (1'b0)
		!reset_n ##1 !reset_n |-> cfg_bits == cfg_bits_pkg::CFG_RESET_VALUE
			&& phase_comp == 4'h0 && voltage_gain_trim == 8'h00)
		else $error("power-on reset left configuration bits set");

	AST_RRR_KEEPS: assert property (
		remote_reset_request && !$past(cfg_wr_en) |-> $stable(cfg_bits)
			##1 (cfg_wr_en || $stable(cfg_bits)))
		else $error("remote reset request disturbed configuration bits");

	AST_RRR_TIMING: assert property (
		remote_reset_request |-> $past(sync_in, 1) && !$past(sync_in, 2)
			&& $past(sel_n_in, 1) && $past(sel_n_in, 4) && $past(sclk_in, 1))
		else $error("remote reset request without a long enough final step");

	AST_RRR_PULSE: assert property (
		remote_reset_request |=> !remote_reset_request [*4])
		else $error("remote reset request longer than one cycle or repeated too soon");

	// main scenarios
	COV_RRR: cover property (remote_reset_request);
	COV_PHASE_MAX: cover property (phase_comp == 4'hF);
	COV_OSC_RAISE: cover property (osc_freq_raise ##1 !osc_freq_raise);
	COV_RRR_AFTER_TRIM: cover property (voltage_gain_trim != 8'h00 ##[1:200] remote_reset_request);

endmodule : metering_calibration_config_bits

`default_nettype wire

// ===== dv/host_cfg_model.sv
// host side model: loads trim bits and drives the remote reset pin sequence
`timescale 1ns/10ps
`default_nettype none

module host_cfg_model (
	input wire logic clk_sys,
	output logic cfg_wr_en,
	output logic [5:0] cfg_wr_addr,
	output logic cfg_wr_bit,
	output logic sel_n_in,
	output logic sync_in,
	output logic sclk_in
);
	// pins rest high as the pull-ups leave them
	initial
	begin
		cfg_wr_en = 1'b0;
		cfg_wr_addr = 6'h00;
		cfg_wr_bit = 1'b0;
		sel_n_in = 1'b1;
		sync_in = 1'b1;
		sclk_in = 1'b1;
	end

	task write_field(input logic [5:0] msb, input int unsigned w, input logic [7:0] v);
		for (int i = 0; i < w; i++)
		begin
			@(negedge clk_sys);
			cfg_wr_en = 1'b1;
			cfg_wr_addr = msb + 6'(i);
			cfg_wr_bit = v[w - 1 - i];
		end
		@(negedge clk_sys);
		cfg_wr_en = 1'b0;
		// released lines flip so a stale value is never mistaken for data
		cfg_wr_addr = ~cfg_wr_addr;
		cfg_wr_bit = ~cfg_wr_bit;
	endtask : write_field

	// hold one pin state for n cycles
	task pins(input logic sel, input logic syn, input int unsigned n);
		@(negedge clk_sys);
		sel_n_in = sel;
		sync_in = syn;
		repeat (n - 1) @(negedge clk_sys);
	endtask : pins

	task remote_reset(input int unsigned step);
		pins(1'b1, 1'b1, step);
		pins(1'b1, 1'b0, step);
		pins(1'b0, 1'b0, step);
		pins(1'b1, 1'b0, step);
		pins(1'b1, 1'b1, 1);
	endtask : remote_reset
endmodule : host_cfg_model
`default_nettype wire

// ===== dv/test_metering_calibration_config_bits.sv
// self-checking bench for the calibration configuration bit store
`timescale 1ns/10ps
`default_nettype none

module test_metering_calibration_config_bits;
	logic clk_sys, reset_n, cfg_wr_en, cfg_wr_bit, sel_n_in, sync_in, sclk_in;
	logic [5:0] cfg_wr_addr, cfg_rd_addr;
	logic cfg_rd_bit, osc_freq_raise, tamper_threshold_sel, remote_reset_request;
	logic [3:0] phase_comp;
	logic [7:0] voltage_gain_trim, secondary_current_gain_trim;
	logic [1:0] oscillator_trim;
	int mismatches;
	int cmp_count;
	// reserved places plus the unmapped top addresses
	logic [5:0] rsv [15] = '{6'h06, 6'h10, 6'h11, 6'h33, 6'h34, 6'h36, 6'h37,
		6'h38, 6'h39, 6'h3A, 6'h3B, 6'h3C, 6'h3D, 6'h3E, 6'h3F};

	metering_calibration_config_bits i_dut (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.cfg_wr_en(cfg_wr_en),
		.cfg_wr_addr(cfg_wr_addr),
		.cfg_wr_bit(cfg_wr_bit),
		.cfg_rd_addr(cfg_rd_addr),
		.sel_n_in(sel_n_in),
		.sync_in(sync_in),
		.sclk_in(sclk_in),
		.cfg_rd_bit(cfg_rd_bit),
		.phase_comp(phase_comp),
		.voltage_gain_trim(voltage_gain_trim),
		.secondary_current_gain_trim(secondary_current_gain_trim),
		.oscillator_trim(oscillator_trim),
		.osc_freq_raise(osc_freq_raise),
		.tamper_threshold_sel(tamper_threshold_sel),
		.remote_reset_request(remote_reset_request)
	);

	host_cfg_model i_host (
		.clk_sys(clk_sys),
		.cfg_wr_en(cfg_wr_en),
		.cfg_wr_addr(cfg_wr_addr),
		.cfg_wr_bit(cfg_wr_bit),
		.sel_n_in(sel_n_in),
		.sync_in(sync_in),
		.sclk_in(sclk_in)
	);

	// 125 MHz system clock
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task summarize;
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize

	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// read answer is registered on the same edge that samples the address
	task rd(input logic [5:0] a, input logic exp);
		@(negedge clk_sys);
		cfg_rd_addr = a;
		@(negedge clk_sys);
		chk({7'h00, cfg_rd_bit}, {7'h00, exp});
	endtask : rd

	// trims are looked at on the second edge after the last bit
	task trims(input logic [3:0] p, input logic [7:0] v, input logic [7:0] s,
		input logic [1:0] o, input logic t);
		@(negedge clk_sys);
		chk({4'h0, phase_comp}, {4'h0, p});
		chk(voltage_gain_trim, v);
		chk(secondary_current_gain_trim, s);
		chk({6'h00, oscillator_trim}, {6'h00, o});
		chk({7'h00, osc_freq_raise}, {7'h00, o == cfg_bits_pkg::OSC_TRIM_RAISE});
		chk({7'h00, tamper_threshold_sel}, {7'h00, t});
	endtask : trims

	task do_reset;
		@(negedge clk_sys);
		reset_n = 1'b0;
		repeat (4) @(negedge clk_sys);
		reset_n = 1'b1;
	endtask : do_reset

	// a hang is cut short and counted
	initial
	begin
		#800000;
		mismatches++;
		summarize();
	end

	initial
	begin
		mismatches = 0;
		cmp_count = 0;
		reset_n = 1'b0;
		cfg_rd_addr = 6'h00;
		do_reset();
		trims(4'h0, 8'h00, 8'h00, 2'h0, 1'b0);
		rd(6'h15, 1'b0);
		i_host.write_field(cfg_bits_pkg::PHASE_COMP_ADDR, 4, 8'h09);
		i_host.write_field(cfg_bits_pkg::VOLTAGE_GAIN_ADDR, 8, 8'hA3);
		i_host.write_field(cfg_bits_pkg::SECONDARY_GAIN_ADDR, 8, 8'h01);
		i_host.write_field(cfg_bits_pkg::TAMPER_SEL_ADDR, 1, 8'h01);
		trims(4'h9, 8'hA3, 8'h01, 2'h0, 1'b1);
		for (int c = 0; c < 4; c++)
		begin
			i_host.write_field(cfg_bits_pkg::OSC_TRIM_ADDR, 2, 8'(c));
			trims(4'h9, 8'hA3, 8'h01, 2'(c), 1'b1);
		end
		// boundary codes of the voltage gain and phase trims
		i_host.write_field(cfg_bits_pkg::VOLTAGE_GAIN_ADDR, 8, 8'hFF);
		i_host.write_field(cfg_bits_pkg::PHASE_COMP_ADDR, 4, 8'h0F);
		i_host.write_field(cfg_bits_pkg::TAMPER_SEL_ADDR, 1, 8'h00);
		trims(4'hF, 8'hFF, 8'h01, 2'h3, 1'b0);
		rd(6'h28, 1'b0);
		rd(6'h2F, 1'b1);
		i_host.write_field(6'h00, 1, 8'h01);
		rd(6'h00, 1'b1);
		rd(6'h01, 1'b0);
		for (int k = 0; k < 15; k++)
		begin
			i_host.write_field(rsv[k], 1, 8'h01);
			rd(rsv[k], 1'b0);
		end
		trims(4'hF, 8'hFF, 8'h01, 2'h3, 1'b0);
		// full pin sequence gives a one-cycle request
		i_host.remote_reset(5);
		@(negedge clk_sys);
		chk({7'h00, remote_reset_request}, 8'h01);
		@(negedge clk_sys);
		chk({7'h00, remote_reset_request}, 8'h00);
		@(negedge clk_sys);
		chk({7'h00, remote_reset_request}, 8'h00);
		trims(4'hF, 8'hFF, 8'h01, 2'h3, 1'b0);
		rd(6'h00, 1'b1);
		// steps too short must not be taken as a request
		i_host.remote_reset(2);
		repeat (8)
		begin
			@(negedge clk_sys);
			chk({7'h00, remote_reset_request}, 8'h00);
		end
		do_reset();
		trims(4'h0, 8'h00, 8'h00, 2'h0, 1'b0);
		rd(6'h00, 1'b0);
		summarize();
	end
endmodule : test_metering_calibration_config_bits
`default_nettype wire
